// ### core/dsr_pkg.sv
// Purpose: shared constants and types for the slew, reset and alert block
// Assumes: 50 MHz clock, 16-bit register data on a 32-bit Avalon-MM word
// Notes:   all offsets are byte addresses of aligned words
package dsr_pkg;

  // ----------------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------------
  localparam logic [5:0] OFS_TARGET_CODE  = 6'h00;
  localparam logic [5:0] OFS_OUT_CFG      = 6'h04;
  localparam logic [5:0] OFS_ACTIVE_CODE  = 6'h08;
  localparam logic [5:0] OFS_CMD_KEY      = 6'h0c;
  localparam logic [5:0] OFS_ALERT_STATUS = 6'h10;
  localparam logic [5:0] OFS_SUPPLY_STAT  = 6'h14;
  localparam logic [5:0] OFS_MODEM_FAULT  = 6'h18;
  localparam logic [5:0] OFS_LIVE_STATUS  = 6'h1c;
  localparam logic [5:0] OFS_ALERT_MASK   = 6'h20;
  localparam logic [5:0] OFS_OVERHEAT_RST = 6'h24;

  // ----------------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------------
  // output config: [0] linear slew enable, [2:1] step, [4:3] rate, [5] modem
  localparam int CFG_LIN_EN_BIT  = 0;
  localparam int CFG_STEP_LSB    = 1;
  localparam int CFG_RATE_LSB    = 3;
  localparam int CFG_MODEM_BIT   = 5;
  localparam int OVERHEAT_EN_BIT = 0;
  // alert status: [5:0] supplies, [6] hot, [7] reset done, [8] supply sum,
  // [9] modem sum
  localparam int AL_HOT_BIT      = 6;
  localparam int AL_RST_BIT      = 7;
  localparam int AL_SUP_SUM_BIT  = 8;
  localparam int AL_MDM_SUM_BIT  = 9;
  localparam int SUP_CALERR_BIT  = 0;
  localparam int NUM_SUPPLIES    = 6;
  localparam logic [15:0] RST_OUT_CFG    = 16'h0000;
  localparam logic [15:0] RST_ALERT_MASK = 16'h0000;
  localparam logic [15:0] RST_CODE       = 16'h0000;
  localparam logic [15:0] KEY_ONE        = 16'h15fa;
  localparam logic [15:0] KEY_TWO        = 16'haf51;
  localparam logic [15:0] CLEAR_ALL      = 16'hffff;

  // ----------------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------------
  localparam int CLK_HZ        = 50_000_000;
  localparam int RATE0_HZ      = 4_000;
  localparam int RATE1_HZ      = 64_000;
  localparam int RATE2_HZ      = 150_000;
  localparam int RATE3_HZ      = 240_000;
  localparam int RESET_TIME_US = 100;
  localparam int RESET_CYC     = CLK_HZ / 1_000_000 * RESET_TIME_US;
  localparam int CODE_W        = 14;
  // step sizes in codes for 0.8, 1.5, 6.1, 22.2 percent of 16384
  localparam logic [13:0] STEP0 = 14'h0083;
  localparam logic [13:0] STEP1 = 14'h00f6;
  localparam logic [13:0] STEP2 = 14'h03e7;
  localparam logic [13:0] STEP3 = 14'h0e35;
  // modem-friendly profile: smallest step at the selected rate
  localparam logic [13:0] STEP_MODEM = 14'h0083;

  typedef enum logic [1:0] {DSR_RUN, DSR_RESET, DSR_KEY1} dsr_mode_t;

  typedef struct packed {
    logic        reload;
    dsr_mode_t   mode;
    logic [31:0] rst_cnt;
    logic [17:0] tick_cnt;
    logic [13:0] target;
    logic [13:0] active;
    logic [5:0]  out_cfg;
    logic        overheat_en;
    logic [15:0] alert;
    logic [15:0] supply;
    logic [15:0] modem;
    logic [15:0] mask;
    logic        early_access;
    logic [2:0]  hot_s;
    logic [2:0]  ohr_s;
    logic [17:0] sup_s;
    logic [8:0]  mdm_s;
    logic [15:0] rdata;
    logic        wait_n;
    logic        alert_n;
    logic        hiz;
  } dsr_state_t;

endpackage

// ### core/dsr_ctrl.sv
// Purpose: dac slew engine, reset sequencer and alert flags behind Avalon-MM
// Assumes: 50 MHz clock, fault inputs are asynchronous levels from outside
// Notes:   reads and writes complete one cycle after they are presented
//
// Summary of operation
// - slew off: written target goes straight to the converter code.
// - slew on: active code steps toward target once per rate tick.
// - step field picks 0.8, 1.5, 6.1 or 22.2 percent of full scale.
// - rate field picks 4, 64, 150 or 240 kHz update ticks.
// - active-code register reads back the code applied now.
// - slew switched off mid-ramp freezes the active code.
// - separate config bit selects gentle modem-friendly slew profile.
// - any reset restores defaults, reloads calibration, channel high-z.
// - reset pin pulsed low gives a full reset.
// - key 0x15fa then 0xaf51 to command-key register resets device.
// - end of reset cycle sets reset-done flag in alert status.
// - bus access during reset sets calibration error in supply status.
// - any unmasked alert drives the active-low alert output.
// - alert status bits are sticky after the condition goes.
// - write one clears a bit; 0xffff clears all.
// - sub-status flags must clear before their summary bits can.
// - live status shows conditions unlatched.
// - mask register gates each condition off the alert pin.
// - six supply monitors set their alert status bits when low.
// - hot die sets the high-temperature alert flag.
// - overheat reset enable makes reset temperature cause full reset.
// - converter code is 14 bits wide.
// - active code mirrors the applied code whatever its source.
//
// Decided for this implementation: register access over Avalon-MM and the register offsets.
`timescale 1ns/10ps
`default_nettype none

module dsr_ctrl
(
  input  wire logic        clk_i,           // 50 mhz clock
  input  wire logic        reset_n_i,       // async reset pin, active low
  input  wire logic [5:0]  avs_address_i,   // byte address
  input  wire logic        avs_read_i,      // read request
  input  wire logic        avs_write_i,     // write request
  input  wire logic [31:0] avs_writedata_i, // write data
  output logic      [31:0] avs_readdata_o,  // read data
  output logic             avs_waitrequest_o, // stall until answer
  input  wire logic [5:0]  supply_low_i,    // supply monitors, async
  input  wire logic        temp_alert_i,    // die at alert temperature
  input  wire logic        temp_reset_i,    // die at reset temperature
  input  wire logic [2:0]  modem_fault_i,   // modem fault events, async
  output logic      [13:0] dac_code_o,      // code to converter
  output logic             chan_hiz_o,      // channel in high impedance
  output logic             cal_reload_o,    // calibration reload active
  output logic             alert_n_o        // alert pin, active low
);
  import dsr_pkg::*;

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  // cycles per update tick, rounded down so the rate is never slower
  function automatic logic [17:0] rate_cycles(input logic [1:0] sel);
    case (sel)
      2'd0:    rate_cycles = 18'(CLK_HZ / RATE0_HZ);
      2'd1:    rate_cycles = 18'(CLK_HZ / RATE1_HZ);
      2'd2:    rate_cycles = 18'(CLK_HZ / RATE2_HZ);
      default: rate_cycles = 18'(CLK_HZ / RATE3_HZ);
    endcase
  endfunction

  function automatic logic [13:0] step_codes(input logic [1:0] sel);
    case (sel)
      2'd0:    step_codes = STEP0;
      2'd1:    step_codes = STEP1;
      2'd2:    step_codes = STEP2;
      default: step_codes = STEP3;
    endcase
  endfunction

  // ----------------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------------
  logic [1:0] rst_sync;
  logic       rst_n;

  // pin reset is asserted at once but released only on a clock edge
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      rst_sync <= 2'b00;
    else
      rst_sync <= {rst_sync[0], 1'b1};
  end
  assign rst_n = rst_sync[1];

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  dsr_state_t q;
  dsr_state_t next_q;
  logic       hot;
  logic       ohr;
  logic [5:0] sup;
  logic [2:0] mdm;
  logic       acc;
  logic       wr;
  logic [15:0] wd;
  logic [15:0] live;
  logic [13:0] step;
  logic [13:0] diff;
  logic        do_reset;

  // synchronised fault levels: a set counts once stages two and three agree, a clear as soon as stage two drops
  assign hot  = q.hot_s[1] & q.hot_s[2];
  assign ohr  = q.ohr_s[1] & q.ohr_s[2];
  assign sup  = q.sup_s[11:6] & q.sup_s[17:12];
  assign mdm  = q.mdm_s[5:3] & q.mdm_s[8:6];
  assign acc  = (avs_read_i | avs_write_i) & ~q.wait_n;
  assign wr   = avs_write_i & ~q.wait_n;
  assign wd   = avs_writedata_i[15:0];
  assign live = {9'h000, hot, sup} & 16'h007f;

  always_comb
  begin
    next_q   = q;
    step     = q.out_cfg[CFG_MODEM_BIT] ? STEP_MODEM
             : step_codes(q.out_cfg[CFG_STEP_LSB +: 2]);
    diff     = (q.target > q.active) ? q.target - q.active
                                     : q.active - q.target;
    do_reset = 1'b0;

    // three-stage capture of outside levels
    next_q.hot_s = {q.hot_s[1:0], temp_alert_i};
    next_q.ohr_s = {q.ohr_s[1:0], temp_reset_i};
    next_q.sup_s = {q.sup_s[11:0], supply_low_i};
    next_q.mdm_s = {q.mdm_s[5:0], modem_fault_i};

    // bus answers one cycle after a request, then raises wait again
    next_q.wait_n = acc;
    next_q.rdata  = 16'h0000;

    case (q.mode)
      DSR_RESET:
      begin
        next_q.hiz = 1'b1;
        if (acc)
          next_q.early_access = 1'b1;
        if (q.rst_cnt == 32'(RESET_CYC - 1))
        begin
          next_q.mode = DSR_RUN;
          next_q.alert[AL_RST_BIT] = 1'b1;
          if (q.early_access | acc)
          begin
            next_q.supply[SUP_CALERR_BIT] = 1'b1;
            next_q.alert[AL_SUP_SUM_BIT] = 1'b1;
          end
        end
        else
          next_q.rst_cnt = q.rst_cnt + 32'd1;
      end
      DSR_RUN, DSR_KEY1:
      begin
        // slew engine
        if (!q.out_cfg[CFG_LIN_EN_BIT] && !q.out_cfg[CFG_MODEM_BIT])
          next_q.tick_cnt = 18'd0;
        else if (q.active != q.target)
        begin
          if (q.tick_cnt >= rate_cycles(q.out_cfg[CFG_RATE_LSB +: 2]) -
              18'd1)
          begin
            next_q.tick_cnt = 18'd0;
            if (diff <= step)
              next_q.active = q.target;
            else if (q.target > q.active)
              next_q.active = q.active + step;
            else
              next_q.active = q.active - step;
          end
          else
            next_q.tick_cnt = q.tick_cnt + 18'd1;
        end

        // register reads
        if (avs_read_i && !q.wait_n)
        begin
          case (avs_address_i)
            OFS_TARGET_CODE:  next_q.rdata = {2'b00, q.target};
            OFS_OUT_CFG:      next_q.rdata = {10'h000, q.out_cfg};
            OFS_ACTIVE_CODE:  next_q.rdata = {2'b00, q.active};
            OFS_ALERT_STATUS: next_q.rdata = q.alert;
            OFS_SUPPLY_STAT:  next_q.rdata = q.supply;
            OFS_MODEM_FAULT:  next_q.rdata = q.modem;
            OFS_LIVE_STATUS:  next_q.rdata = live;
            OFS_ALERT_MASK:   next_q.rdata = q.mask;
            OFS_OVERHEAT_RST: next_q.rdata = {15'h0000, q.overheat_en};
            default:          next_q.rdata = 16'h0000;
          endcase
        end

        // write-one-to-clear of sub-status flags
        if (wr && avs_address_i == OFS_SUPPLY_STAT)
          next_q.supply = q.supply & ~wd;
        if (wr && avs_address_i == OFS_MODEM_FAULT)
          next_q.modem = q.modem & ~wd;

        // register writes
        if (wr)
        begin
          case (avs_address_i)
            OFS_TARGET_CODE:
            begin
              next_q.target = wd[CODE_W-1:0];
              if (!q.out_cfg[CFG_LIN_EN_BIT] && !q.out_cfg[CFG_MODEM_BIT])
                next_q.active = wd[CODE_W-1:0];
            end
            OFS_OUT_CFG:      next_q.out_cfg = wd[5:0];
            OFS_ALERT_MASK:   next_q.mask = wd;
            OFS_OVERHEAT_RST: next_q.overheat_en = wd[OVERHEAT_EN_BIT];
            OFS_ALERT_STATUS:
            begin
              // summary bits only clear once their source is empty
              next_q.alert = q.alert & ~wd;
              if (q.supply != 16'h0000)
                next_q.alert[AL_SUP_SUM_BIT] = q.alert[AL_SUP_SUM_BIT];
              if (q.modem != 16'h0000)
                next_q.alert[AL_MDM_SUM_BIT] = q.alert[AL_MDM_SUM_BIT];
            end
            OFS_CMD_KEY:
            begin
              if (q.mode == DSR_KEY1 && wd == KEY_TWO)
                do_reset = 1'b1;
              next_q.mode = (wd == KEY_ONE) ? DSR_KEY1 : DSR_RUN;
            end
            default: ;
          endcase
        end

        if (q.overheat_en && ohr)
          do_reset = 1'b1;
      end
      default: next_q.mode = DSR_RESET;
    endcase

    // sticky sets win over a clear in the same cycle
    next_q.alert[NUM_SUPPLIES-1:0] = next_q.alert[NUM_SUPPLIES-1:0] |
                                     sup;
    if (hot)
      next_q.alert[AL_HOT_BIT] = 1'b1;
    // modem faults latch only after they pass the synchroniser
    next_q.modem[2:0] = next_q.modem[2:0] | mdm;
    if (|mdm)
      next_q.alert[AL_MDM_SUM_BIT] = 1'b1;

    if (q.mode != DSR_RESET)
      next_q.hiz = 1'b0;

    // a software or thermal reset restarts the full reset cycle
    if (do_reset)
    begin
      next_q = '0;
      next_q.mode   = DSR_RESET;
      next_q.hiz    = 1'b1;
      next_q.mask   = RST_ALERT_MASK;
      next_q.out_cfg = RST_OUT_CFG[5:0];
      next_q.hot_s  = q.hot_s;
      next_q.ohr_s  = q.ohr_s;
      next_q.sup_s  = q.sup_s;
      next_q.mdm_s  = q.mdm_s;
      next_q.wait_n = acc;
    end

    // registered so the reload output comes straight from a flop
    next_q.reload  = (next_q.mode == DSR_RESET);
    next_q.alert_n = ~|(next_q.alert & ~next_q.mask);
  end

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      q         <= '0;
      q.mode    <= DSR_RESET;
      q.hiz     <= 1'b1;
      q.alert_n <= 1'b1;
      q.reload  <= 1'b1;
    end
    else
      q <= next_q;
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  assign avs_readdata_o    = {16'h0000, q.rdata};
  assign avs_waitrequest_o = ~q.wait_n;
  assign dac_code_o        = q.active;
  assign chan_hiz_o        = q.hiz;
  assign cal_reload_o      = q.reload;
  assign alert_n_o         = q.alert_n;

endmodule

`default_nettype wire

// ### verif/dsr_ctrl_asserts.sv
// Purpose: concurrent checks on the slew, reset and alert block
// Assumes: one clock; reset pin async, active low
// Notes:   slew enable and target are shadowed from taken writes
`timescale 1ns/10ps
`default_nettype none
module dsr_ctrl_asserts
  import dsr_pkg::*;
(
  input wire logic        clk_i,             // clock
  input wire logic        reset_n_i,         // reset pin
  input wire logic [5:0]  avs_address_i,     // byte address
  input wire logic        avs_read_i,        // read request
  input wire logic        avs_write_i,       // write request
  input wire logic [31:0] avs_writedata_i,   // write data
  input wire logic        avs_waitrequest_o, // stall
  input wire logic [13:0] dac_code_o,        // applied code
  input wire logic        chan_hiz_o,        // high-z
  input wire logic        cal_reload_o,      // reset cycle
  input wire logic        alert_n_o          // alert pin
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  logic        slew_en;
  logic        tgt_hit;
  logic [13:0] tgt_q;
  logic        taken;
  logic        key_armed;
  assign taken = avs_write_i && !avs_waitrequest_o;
  // shadow state; a reset cycle wipes slew_en and key_armed, but tgt_q keeps its value
  always_ff @(posedge clk_i)
  begin
    tgt_hit <= taken && avs_address_i == OFS_TARGET_CODE;
    if (taken && avs_address_i == OFS_TARGET_CODE)
      tgt_q <= avs_writedata_i[13:0];
    if (cal_reload_o)
      slew_en <= 1'b0;
    else if (taken && avs_address_i == OFS_OUT_CFG)
      slew_en <= avs_writedata_i[CFG_LIN_EN_BIT] |
                 avs_writedata_i[CFG_MODEM_BIT];
    // the second key only counts right after the first one
    if (cal_reload_o)
      key_armed <= 1'b0;
    else if (taken && avs_address_i == OFS_CMD_KEY)
      key_armed <= avs_writedata_i[15:0] == KEY_ONE;
  end
  sequence key_one_s;
    taken && avs_address_i == OFS_CMD_KEY
    && avs_writedata_i[15:0] == KEY_ONE;
  endsequence
  sequence key_two_s;
    taken && key_armed && avs_address_i == OFS_CMD_KEY
    && avs_writedata_i[15:0] == KEY_TWO;
  endsequence
  wait_stands_a: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("waitrequest low longer than one cycle");
  answer_time_a: assert property ((avs_read_i || avs_write_i)
    && avs_waitrequest_o |-> ##[1:3] !avs_waitrequest_o)
    else $error("request not answered in time");
  hiz_reset_a: assert property (cal_reload_o |-> chan_hiz_o)
    else $error("channel not high-z during reset cycle");
  code_reset_a: assert property (
    cal_reload_o |-> dac_code_o == 14'h0000)
    else $error("code not cleared during reset cycle");
  pin_reset_a: assert property (
    $rose(reset_n_i) |=> cal_reload_o [*3])
    else $error("pin reset did not start a reset cycle");
  key_reset_a: assert property (key_one_s ##[1:20] key_two_s
    |-> ##[1:4] cal_reload_o)
    else $error("key pair did not reset");
  done_alert_a: assert property (
    $fell(cal_reload_o) |-> ##[0:3] !alert_n_o)
    else $error("reset done did not raise alert");
  jump_code_a: assert property (tgt_hit && !slew_en && !cal_reload_o
    |-> ##[0:2] dac_code_o == tgt_q)
    else $error("target not applied at once");
  code_hold_a: assert property (!slew_en && !avs_write_i
    && !cal_reload_o && !$past(avs_write_i)
    |=> $stable(dac_code_o) || cal_reload_o)
    else $error("code moved with slew off");
endmodule
bind dsr_ctrl dsr_ctrl_asserts chk_u (.clk_i(clk_i), .reset_n_i(reset_n_i),
  .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
  .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
  .avs_waitrequest_o(avs_waitrequest_o), .dac_code_o(dac_code_o),
  .chan_hiz_o(chan_hiz_o), .cal_reload_o(cal_reload_o),
  .alert_n_o(alert_n_o));
`default_nettype wire

// ### verif/dsr_host.sv
// Purpose: host model driving the register bus
// Assumes: slave answers by dropping waitrequest
// Notes:   released lines show inverted values, never a stale copy
`timescale 1ns/10ps
`default_nettype none
module dsr_host
  import dsr_pkg::*;
(
  input  wire logic        clk_i,         // bus clock
  input  wire logic        waitrequest_i, // slave stall
  output var  logic [5:0]  address_o,     // byte address
  output var  logic        read_o,        // read request
  output var  logic        write_o,       // write request
  output var  logic [31:0] writedata_o    // write data
);
  initial
  begin
    read_o = 1'b0;
    write_o = 1'b0;
    address_o = 6'h00;
    writedata_o = 32'h0;
  end
  // one transfer, held until the edge that sees waitrequest low
  task automatic xfer(input logic w, input logic [5:0] a,
                      input logic [15:0] d);
    @(posedge clk_i);
    read_o <= !w;
    write_o <= w;
    address_o <= a;
    writedata_o <= {16'h0000, d};
    @(posedge clk_i);
    while (waitrequest_i) @(posedge clk_i);
    read_o <= 1'b0;
    write_o <= 1'b0;
    address_o <= ~a;
    writedata_o <= ~{16'h0000, d};
  endtask
  // keys strictly in order, nothing between them
  task automatic soft_reset;
    xfer(1'b1, OFS_CMD_KEY, KEY_ONE);
    xfer(1'b1, OFS_CMD_KEY, KEY_TWO);
  endtask
  // sub-status first, summary last, or the summary bits stay set
  task automatic clear_flags;
    xfer(1'b1, OFS_SUPPLY_STAT, CLEAR_ALL);
    xfer(1'b1, OFS_MODEM_FAULT, CLEAR_ALL);
    xfer(1'b1, OFS_ALERT_STATUS, CLEAR_ALL);
  endtask
endmodule
`default_nettype wire

// ### verif/tb_top.sv
// Purpose: self-checking bench for the slew, reset and alert block
// Assumes: 50 mhz clock; reset cycle of RESET_CYC clocks
// Notes:   reads queue expected data; a watcher compares at the answer
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import dsr_pkg::*;
  logic clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic [5:0] sup = 6'h00;
  logic ta = 1'b0;
  logic tr = 1'b0;
  logic [2:0] mf = 3'h0;
  logic [5:0] adr;
  logic rd_s, wr_s, wait_s, aln, hiz, rld;
  logic [31:0] wd, rdat;
  logic [13:0] dac;
  logic [16:0] exp_q[$];
  logic [16:0] e;
  logic [15:0] lfsr_q = 16'h0008;
  int error_cnt = 0;
  int tests_run = 0;
  int n;
  always #10 clk_i = ~clk_i;
  dsr_ctrl dut_u (.clk_i(clk_i), .reset_n_i(reset_n_i), .avs_address_i(adr),
    .avs_read_i(rd_s), .avs_write_i(wr_s), .avs_writedata_i(wd),
    .avs_readdata_o(rdat), .avs_waitrequest_o(wait_s),
    .supply_low_i(sup), .temp_alert_i(ta), .temp_reset_i(tr),
    .modem_fault_i(mf), .dac_code_o(dac), .chan_hiz_o(hiz),
    .cal_reload_o(rld), .alert_n_o(aln));
  dsr_host host_u (.clk_i(clk_i), .waitrequest_i(wait_s), .address_o(adr),
    .read_o(rd_s), .write_o(wr_s), .writedata_o(wd));
  function automatic logic [15:0] nxt(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic chk(input string nm, input logic [15:0] x,
                     input logic [15:0] s);
    tests_run++;
    if (s !== x)
    begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, x, s);
    end
  endtask
  task automatic give_verdict;
    if (error_cnt == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // queue the expectation, then let the host fetch it
  task automatic rd(input logic [5:0] a, input logic c, input logic [15:0] v);
    exp_q.push_back({c, v});
    host_u.xfer(1'b0, a, 16'h0000);
  endtask
  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    host_u.xfer(1'b1, a, d);
  endtask
  task automatic wait_reload;
    for (n = 0; n < RESET_CYC + 50 && rld !== 1'b0; n++) @(posedge clk_i);
  endtask
  // first step size and the spacing of the first two steps
  task automatic ramp(input logic [15:0] cfg, input logic [13:0] st,
                      input int p);
    wr(OFS_OUT_CFG, 16'h0000);
    wr(OFS_TARGET_CODE, 16'h0000);
    wr(OFS_OUT_CFG, cfg);
    wr(OFS_TARGET_CODE, 16'h3fff);
    for (n = 0; n < 20000 && dac === 14'h0; n++) @(posedge clk_i);
    chk("first_step", {2'b0, st}, {2'b0, dac});
    for (n = 0; n < 20000 && dac === st; n++) @(posedge clk_i);
    chk("tick_gap", 16'h1, {15'h0, n >= p - 1 && n <= p + 1});
  endtask
  // read answers are matched to the oldest note at the answering edge
  always @(posedge clk_i)
    if (rd_s && !wait_s && exp_q.size() > 0)
    begin
      e = exp_q.pop_front();
      if (e[16]) chk("readdata", e[15:0], rdat[15:0]);
    end
  // the run needs about 45k cycles; a hang ends in the same verdict
  initial
  begin
    #(60000 * 20);
    error_cnt++;
    give_verdict();
  end
  initial
  begin
    logic [13:0] stp[4] = '{STEP0, STEP1, STEP2, STEP3};
    int rt[4] = '{RATE0_HZ, RATE1_HZ, RATE2_HZ, RATE3_HZ};
    repeat (3) @(posedge clk_i);
    reset_n_i <= 1'b1;
    repeat (6) @(posedge clk_i);
    rd(OFS_SUPPLY_STAT, 1'b0, 16'h0);
    wait_reload();
    repeat (3) @(posedge clk_i);
    chk("alert_n", 16'h0, {15'h0, aln});
    rd(OFS_ALERT_STATUS, 1'b1, 16'h0180);
    rd(OFS_SUPPLY_STAT, 1'b1, 16'h0001);
    wr(OFS_ALERT_STATUS, CLEAR_ALL);
    rd(OFS_ALERT_STATUS, 1'b1, 16'h0100);
    host_u.clear_flags();
    rd(OFS_ALERT_STATUS, 1'b1, 16'h0000);
    chk("alert_n", 16'h1, {15'h0, aln});
    repeat (4)
    begin
      lfsr_q = nxt(lfsr_q);
      wr(OFS_TARGET_CODE, {2'b00, lfsr_q[13:0]});
      rd(OFS_ACTIVE_CODE, 1'b1, {2'b00, lfsr_q[13:0]});
    end
    for (int s = 0; s < 4; s++)
      ramp(16'h1 | 16'(s << 1) | 16'(s << 3), stp[s], CLK_HZ / rt[s]);
    repeat (1000) @(posedge clk_i);
    chk("dac_end", 16'h3fff, {2'b0, dac});
    wr(OFS_TARGET_CODE, 16'h0000);
    for (n = 0; n < 400 && dac === 14'h3fff; n++) @(posedge clk_i);
    wr(OFS_OUT_CFG, 16'h0000);
    repeat (500) @(posedge clk_i);
    rd(OFS_ACTIVE_CODE, 1'b1, 16'h3fff - {2'b0, STEP3});
    ramp(16'h003f, STEP_MODEM, CLK_HZ / RATE3_HZ);
    wr(OFS_OUT_CFG, 16'h0000);
    lfsr_q = nxt(lfsr_q);
    sup <= lfsr_q[5:0] | 6'h01;
    ta <= 1'b1;
    repeat (8) @(posedge clk_i);
    rd(OFS_LIVE_STATUS, 1'b1, {9'h0, 1'b1, lfsr_q[5:0] | 6'h01});
    sup <= 6'h00;
    ta <= 1'b0;
    mf <= 3'h5;
    repeat (8) @(posedge clk_i);
    mf <= 3'h0;
    repeat (8) @(posedge clk_i);
    rd(OFS_LIVE_STATUS, 1'b1, 16'h0000);
    rd(OFS_ALERT_STATUS, 1'b1, {6'h04, 1'b1, lfsr_q[5:0] | 6'h01});
    rd(OFS_MODEM_FAULT, 1'b1, 16'h0005);
    wr(OFS_ALERT_MASK, 16'h03ff);
    repeat (4) @(posedge clk_i);
    chk("alert_n", 16'h1, {15'h0, aln});
    wr(OFS_ALERT_MASK, 16'h0000);
    repeat (4) @(posedge clk_i);
    chk("alert_n", 16'h0, {15'h0, aln});
    host_u.clear_flags();
    rd(OFS_ALERT_STATUS, 1'b1, 16'h0000);
    wr(OFS_CMD_KEY, KEY_ONE);
    wr(OFS_CMD_KEY, 16'h0000);
    wr(OFS_CMD_KEY, KEY_TWO);
    repeat (4) @(posedge clk_i);
    chk("reload", 16'h0, {15'h0, rld});
    host_u.soft_reset();
    repeat (3) @(posedge clk_i);
    chk("reload", 16'h1, {15'h0, rld});
    chk("hiz", 16'h1, {15'h0, hiz});
    wait_reload();
    rd(OFS_ACTIVE_CODE, 1'b1, RST_CODE);
    rd(OFS_OUT_CFG, 1'b1, RST_OUT_CFG);
    host_u.clear_flags();
    wr(OFS_OVERHEAT_RST, 16'h0001);
    tr <= 1'b1;
    repeat (8) @(posedge clk_i);
    chk("reload", 16'h1, {15'h0, rld});
    tr <= 1'b0;
    wait_reload();
    rd(OFS_OVERHEAT_RST, 1'b1, 16'h0000);
    rd(6'h3c, 1'b1, 16'h0000);
    repeat (4) @(posedge clk_i);
    give_verdict();
  end
endmodule
`default_nettype wire
